// File: core/err_recorder.sv
/*
  Event report recorder top: continuous pre-trigger sample ring, report
  capture into a circular report store, change-of-state log, Avalon-MM
  register slave and one level interrupt.
  Assumes samples, trigger equation and watched conditions come from
  protection logic on core_clk, and samples arrive well below clock rate.
*/
// Design decisions made here: the Avalon-MM register port and the register offsets.
// Contract
// - the length setting selects a report span of 15, 30 or 60 cycles.
// - a prefault length of 1 to 59 cycles forms the leading part of each report.
// - captured reports are held in storage that survives power loss.
// - capacity is eight 15-cycle, four 30-cycle or two 60-cycle reports.
// - a new report when full replaces the oldest stored report.
// - any change of the length setting clears every stored report.
// - changing the prefault length leaves stored reports untouched.
// - each report carries date, time, current, voltage, frequency, element, input and output states.
// - every change of a watched condition appends one stamped line to the change log.
// - the change log keeps the latest 512 lines and then overwrites the oldest.
// - the serial trigger command captures a standard report.
// - a 0 to 1 edge of the trigger equation starts a report unless one in progress covers it; the code also ignores edges during the ERR_COPY copy-out.
`timescale 1ns/1ps
`default_nettype none

module err_recorder
  import err_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  input  wire logic               sample_valid,
  input  wire logic [CUR_W-1:0]   sample_current,
  input  wire logic [VOLT_W-1:0]  sample_voltage,
  input  wire logic [FREQ_W-1:0]  sample_frequency,
  input  wire logic [ELEM_W-1:0]  element_states,
  input  wire logic [IN_W-1:0]    input_states,
  input  wire logic [OUT_W-1:0]   output_states,
  input  wire logic [TS_W-1:0]    date_time,
  input  wire logic               report_trigger_equation,
  input  wire logic [WATCH_W-1:0] watched_conditions,
  output logic                    irq
);

  typedef enum logic [1:0] {
    ERR_IDLE = 2'b00,
    ERR_POST = 2'b01,
    ERR_COPY = 2'b10
  } err_state_e;

  // span in cycles for a length code
  function automatic logic [6:0] len_cycles(input logic [1:0] sel);
    case (sel)
      ERR_LEN_15: len_cycles = CYC_SHORT;
      ERR_LEN_30: len_cycles = CYC_MID;
      default:    len_cycles = CYC_LONG;
    endcase
  endfunction

  // reports held for a length code
  function automatic logic [3:0] len_slots(input logic [1:0] sel);
    case (sel)
      ERR_LEN_15: len_slots = CAP_SHORT;
      ERR_LEN_30: len_slots = CAP_MID;
      default:    len_slots = CAP_LONG;
    endcase
  endfunction

  function automatic logic [STORE_AW-1:0] cyc_words(input logic [6:0] cyc);
    cyc_words = STORE_AW'(cyc * SPC);
  endfunction

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // storage arrays, no reset: they stand for nonvolatile memory
  logic [SMP_W-1:0]    ring [2**RING_AW];
  logic [SMP_W-1:0]    store [STORE_N];
  logic [TS_W-1:0]     slot_stamp [SLOT_N];

  logic [1:0]          len_sel, next_len_sel;
  logic [5:0]          pre_len, next_pre_len;
  logic [IRQ_W-1:0]    irq_stat, next_irq_stat;
  logic [IRQ_W-1:0]    irq_mask, next_irq_mask;
  logic [2:0]          rep_sel, next_rep_sel;
  logic [7:0]          rep_addr, next_rep_addr;
  logic [WATCH_W-1:0]  log_mask, next_log_mask;
  logic [LOG_AW-1:0]   log_index, next_log_index;
  logic [31:0]         next_readdata;
  logic                rd_ack, next_rd_ack;
  logic                cmd_trig;
  logic                len_change;

  err_state_e          state, next_state;
  logic [RING_AW-1:0]  ring_wp, next_ring_wp;
  logic [RING_AW-1:0]  start_ptr, next_start_ptr;
  logic [STORE_AW-1:0] post_left, next_post_left;
  logic [STORE_AW-1:0] copy_idx, next_copy_idx;
  logic [STORE_AW-1:0] cap_words, next_cap_words;
  logic [TS_W-1:0]     cap_stamp, next_cap_stamp;
  logic [2:0]          slot_wp, next_slot_wp;
  logic [SLOT_N-1:0]   slot_valid, next_slot_valid;
  logic                trig_q, next_trig_q;
  logic                trig_start;
  logic                copy_we;
  logic                rep_done;
  logic [5:0]          pre_eff;
  logic [STORE_AW-1:0] len_words;
  logic [STORE_AW-1:0] store_wa;
  logic [STORE_AW-1:0] store_ra;
  logic [SMP_W-1:0]    sample_word;

  logic [TS_W-1:0]     log_stamp;
  logic [WATCH_W-1:0]  log_state;
  logic [LOG_AW:0]     log_count;
  logic                log_added;

  err_change_log u_log (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .watch      (watched_conditions),
    .watch_mask (log_mask),
    .stamp      (date_time),
    .rd_index   (log_index),
    .rd_stamp   (log_stamp),
    .rd_state   (log_state),
    .line_count (log_count),
    .line_added (log_added)
  );

  // every field of a report sample travels together
  assign sample_word = {sample_current, sample_voltage, sample_frequency,
                        element_states, input_states, output_states};
  assign len_words   = cyc_words(len_cycles(len_sel));
  // prefault never swallows the whole span, one post cycle kept
  assign pre_eff     = (7'(pre_len) >= len_cycles(len_sel))
                       ? 6'(len_cycles(len_sel) - 7'd1) : pre_len;
  assign cmd_trig    = avs_write && (avs_address == REG_CMD)
                       && avs_writedata[CMD_TRIG_BIT];
  assign len_change  = avs_write && (avs_address == REG_CTRL)
                       && (avs_writedata[CTRL_LEN_MSB:CTRL_LEN_LSB] != len_sel)
                       && (avs_writedata[CTRL_LEN_MSB:CTRL_LEN_LSB] != 2'b11);

  // capture engine: ring write, trigger, post collection, copy out
  always_comb begin
    next_state      = state;
    next_ring_wp    = ring_wp;
    next_start_ptr  = start_ptr;
    next_post_left  = post_left;
    next_copy_idx   = copy_idx;
    next_cap_words  = cap_words;
    next_cap_stamp  = cap_stamp;
    next_slot_wp    = slot_wp;
    next_slot_valid = slot_valid;
    next_trig_q     = report_trigger_equation;
    copy_we         = 1'b0;
    rep_done        = 1'b0;
    // edge from 0 to 1 or the command; ignored while a capture runs
    trig_start      = (report_trigger_equation && !trig_q) || cmd_trig;
    if (sample_valid)
      next_ring_wp = ring_wp + 1'b1;  // runs regardless of capture
    case (state)
      ERR_IDLE: begin
        if (trig_start) begin
          next_start_ptr = ring_wp - RING_AW'(cyc_words(7'(pre_eff)));
          next_post_left = len_words - cyc_words(7'(pre_eff));
          next_cap_words = len_words;
          next_cap_stamp = date_time;
          next_state     = ERR_POST;
        end
      end
      ERR_POST: begin
        if (post_left == '0) begin
          next_copy_idx = '0;
          next_state    = ERR_COPY;
        end else if (sample_valid) begin
          next_post_left = post_left - 1'b1;
        end
      end
      ERR_COPY: begin
        copy_we = 1'b1;
        if (copy_idx == cap_words - 1'b1) begin
          rep_done                 = 1'b1;
          next_slot_valid[slot_wp] = 1'b1;
          // newest lands on the oldest slot once all are used
          next_slot_wp = (4'(slot_wp) + 4'd1 >= len_slots(len_sel))
                         ? 3'd0 : slot_wp + 3'd1;
          next_state   = ERR_IDLE;
        end else begin
          next_copy_idx = copy_idx + 1'b1;
        end
      end
      default: next_state = ERR_IDLE;
    endcase
    if (len_change) begin  // drop every report and any capture
      next_slot_valid = '0;
      next_slot_wp    = '0;
      next_state      = ERR_IDLE;
      copy_we         = 1'b0;
      rep_done        = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ERR_IDLE;
      ring_wp    <= '0;
      start_ptr  <= '0;
      post_left  <= '0;
      copy_idx   <= '0;
      cap_words  <= '0;
      cap_stamp  <= '0;
      slot_wp    <= '0;
      slot_valid <= '0;
      trig_q     <= 1'b0;
    end else begin
      state      <= next_state;
      ring_wp    <= next_ring_wp;
      start_ptr  <= next_start_ptr;
      post_left  <= next_post_left;
      copy_idx   <= next_copy_idx;
      cap_words  <= next_cap_words;
      cap_stamp  <= next_cap_stamp;
      slot_wp    <= next_slot_wp;
      slot_valid <= next_slot_valid;
      trig_q     <= next_trig_q;
    end
  end

  // slot base is slot index times span, so slots never overlap
  assign store_wa = STORE_AW'(slot_wp * cap_words) + copy_idx;
  assign store_ra = STORE_AW'(rep_sel * len_words) + STORE_AW'(rep_addr);

  // memory writes
  always_ff @(posedge core_clk) begin
    if (sample_valid)
      ring[ring_wp] <= sample_word;
    if (copy_we)
      store[store_wa] <= ring[start_ptr + RING_AW'(copy_idx)];
    if (copy_we && rep_done)
      slot_stamp[slot_wp] <= cap_stamp;
  end

  // register writes; hardware set wins over write-one-to-clear
  always_comb begin
    next_len_sel   = len_sel;
    next_pre_len   = pre_len;
    next_irq_mask  = irq_mask;
    next_rep_sel   = rep_sel;
    next_rep_addr  = rep_addr;
    next_log_mask  = log_mask;
    next_log_index = log_index;
    next_irq_stat  = irq_stat;
    if (avs_write) begin
      case (avs_address)
        REG_CTRL: begin
          if (avs_writedata[CTRL_LEN_MSB:CTRL_LEN_LSB] != 2'b11)
            next_len_sel = avs_writedata[CTRL_LEN_MSB:CTRL_LEN_LSB];
          // prefault alone touches no stored report
          if (avs_writedata[CTRL_PRE_MSB:CTRL_PRE_LSB] >= PRE_MIN &&
              avs_writedata[CTRL_PRE_MSB:CTRL_PRE_LSB] <= PRE_MAX)
            next_pre_len = avs_writedata[CTRL_PRE_MSB:CTRL_PRE_LSB];
        end
        REG_IRQ_STAT:  next_irq_stat  = irq_stat & ~avs_writedata[IRQ_W-1:0];
        REG_IRQ_MASK:  next_irq_mask  = avs_writedata[IRQ_W-1:0];
        REG_REP_SEL:   next_rep_sel   = avs_writedata[2:0];
        REG_REP_ADDR:  next_rep_addr  = avs_writedata[7:0];
        REG_LOG_MASK:  next_log_mask  = avs_writedata[WATCH_W-1:0];
        REG_LOG_INDEX: next_log_index = avs_writedata[LOG_AW-1:0];
        default: ;
      endcase
    end
    if (rep_done)
      next_irq_stat[IRQ_REP_BIT] = 1'b1;
    if (log_added)
      next_irq_stat[IRQ_LOG_BIT] = 1'b1;
  end

  // read data; one wait state while the answer is registered
  always_comb begin
    next_rd_ack   = avs_read && !rd_ack;
    next_readdata = avs_readdata;
    if (avs_read && !rd_ack) begin
      next_readdata = '0;
      case (avs_address)
        REG_CTRL: begin
          next_readdata[CTRL_LEN_MSB:CTRL_LEN_LSB] = len_sel;
          next_readdata[CTRL_PRE_MSB:CTRL_PRE_LSB] = pre_len;
        end
        REG_STATUS: begin
          next_readdata[ST_BUSY_BIT]               = (state != ERR_IDLE);
          next_readdata[ST_VALID_MSB:ST_VALID_LSB] = slot_valid;
          next_readdata[ST_NEXT_MSB:ST_NEXT_LSB]   = slot_wp;
        end
        REG_IRQ_STAT:  next_readdata[IRQ_W-1:0]   = irq_stat;
        REG_IRQ_MASK:  next_readdata[IRQ_W-1:0]   = irq_mask;
        REG_REP_SEL:   next_readdata[2:0]         = rep_sel;
        REG_REP_ADDR:  next_readdata[7:0]         = rep_addr;
        REG_REP_LO:    next_readdata              = store[store_ra][31:0];
        REG_REP_HI:    next_readdata              = store[store_ra][SMP_W-1:32];
        REG_REP_STAMP: next_readdata              = slot_stamp[rep_sel];
        REG_LOG_MASK:  next_readdata[WATCH_W-1:0] = log_mask;
        REG_LOG_INDEX: next_readdata[LOG_AW-1:0]  = log_index;
        REG_LOG_STAMP: next_readdata              = log_stamp;
        REG_LOG_STATE: next_readdata[WATCH_W-1:0] = log_state;
        REG_LOG_COUNT: next_readdata[LOG_AW:0]    = log_count;
        default:       next_readdata              = '0;  // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_sel      <= ERR_LEN_15;
      pre_len      <= PRE_RST;
      irq_stat     <= '0;
      irq_mask     <= '0;
      rep_sel      <= '0;
      rep_addr     <= '0;
      log_mask     <= '0;
      log_index    <= '0;
      rd_ack       <= 1'b0;
      avs_readdata <= '0;
    end else begin
      len_sel      <= next_len_sel;
      pre_len      <= next_pre_len;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
      rep_sel      <= next_rep_sel;
      rep_addr     <= next_rep_addr;
      log_mask     <= next_log_mask;
      log_index    <= next_log_index;
      rd_ack       <= next_rd_ack;
      avs_readdata <= next_readdata;
    end
  end

  assign avs_waitrequest = avs_read && !rd_ack;
  assign irq             = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

// File: core/err_pkg.sv
/*
  Shared constants for the event report recorder: sample framing,
  report lengths and capacities, change log sizing and the register map.
  Assumes a single 250 MHz core clock and word-aligned Avalon-MM access.
*/
package err_pkg;

  // sample framing
  localparam int          SPC       = 4;   // samples per power-system cycle
  localparam int          SMP_W     = 64;  // packed sample width
  localparam int          TS_W      = 32;  // date/time stamp width
  localparam int          CUR_W     = 16;
  localparam int          VOLT_W    = 16;
  localparam int          FREQ_W    = 16;
  localparam int          ELEM_W    = 8;
  localparam int          IN_W      = 4;
  localparam int          OUT_W     = 4;

  // report lengths in cycles and capacities in reports
  localparam logic [6:0]  CYC_SHORT = 7'd15;
  localparam logic [6:0]  CYC_MID   = 7'd30;
  localparam logic [6:0]  CYC_LONG  = 7'd60;
  localparam logic [3:0]  CAP_SHORT = 4'd8;
  localparam logic [3:0]  CAP_MID   = 4'd4;
  localparam logic [3:0]  CAP_LONG  = 4'd2;
  localparam logic [5:0]  PRE_MIN   = 6'd1;
  localparam logic [5:0]  PRE_MAX   = 6'd59;
  localparam logic [5:0]  PRE_RST   = 6'd4;

  typedef enum logic [1:0] {
    ERR_LEN_15 = 2'b00,
    ERR_LEN_30 = 2'b01,
    ERR_LEN_60 = 2'b10
  } err_len_e;

  // storage sizing
  localparam int          RING_AW   = 9;   // pre-trigger ring, 128 cycles deep
  localparam int          STORE_AW  = 9;
  localparam int          STORE_N   = 480; // 8 x 15 x SPC words
  localparam int          SLOT_N    = 8;
  localparam int          WATCH_W   = 16;
  localparam int          LOG_AW    = 9;
  localparam int          LOG_N     = 512;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_CMD       = 8'h04;
  localparam logic [7:0]  REG_STATUS    = 8'h08;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h0C;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h10;
  localparam logic [7:0]  REG_REP_SEL   = 8'h14;
  localparam logic [7:0]  REG_REP_ADDR  = 8'h18;
  localparam logic [7:0]  REG_REP_LO    = 8'h1C;
  localparam logic [7:0]  REG_REP_HI    = 8'h20;
  localparam logic [7:0]  REG_REP_STAMP = 8'h24;
  localparam logic [7:0]  REG_LOG_MASK  = 8'h28;
  localparam logic [7:0]  REG_LOG_INDEX = 8'h2C;
  localparam logic [7:0]  REG_LOG_STAMP = 8'h30;
  localparam logic [7:0]  REG_LOG_STATE = 8'h34;
  localparam logic [7:0]  REG_LOG_COUNT = 8'h38;

  // field positions
  localparam int          CTRL_LEN_LSB  = 0;
  localparam int          CTRL_LEN_MSB  = 1;
  localparam int          CTRL_PRE_LSB  = 8;
  localparam int          CTRL_PRE_MSB  = 13;
  localparam int          CMD_TRIG_BIT  = 0;
  localparam int          IRQ_REP_BIT   = 0;
  localparam int          IRQ_LOG_BIT   = 1;
  localparam int          IRQ_W         = 2;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_VALID_LSB  = 8;
  localparam int          ST_VALID_MSB  = 15;
  localparam int          ST_NEXT_LSB   = 16;
  localparam int          ST_NEXT_MSB   = 18;

endpackage

// File: core/err_change_log.sv
/*
  Change-of-state log: appends one stamped line whenever a watched
  condition changes, 512 lines deep, oldest line overwritten once full.
  Assumes watched conditions come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module err_change_log
  import err_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [WATCH_W-1:0] watch,
  input  wire logic [WATCH_W-1:0] watch_mask,
  input  wire logic [TS_W-1:0]    stamp,
  input  wire logic [LOG_AW-1:0]  rd_index,
  output logic      [TS_W-1:0]    rd_stamp,
  output logic      [WATCH_W-1:0] rd_state,
  output logic      [LOG_AW:0]    line_count,
  output logic                    line_added
);

  logic [TS_W+WATCH_W-1:0] lines [LOG_N];  // kept across power loss
  logic [WATCH_W-1:0]      prev;
  logic [WATCH_W-1:0]      next_prev;
  logic                    primed;
  logic                    next_primed;
  logic [LOG_AW-1:0]       wp;
  logic [LOG_AW-1:0]       next_wp;
  logic [LOG_AW:0]         next_count;
  logic                    change;
  logic [LOG_AW-1:0]       rd_phys;

  // first cycle after reset only primes the history, no spurious line
  always_comb begin
    change      = primed && (((watch ^ prev) & watch_mask) != '0);
    next_prev   = watch;
    next_primed = 1'b1;
    next_wp     = wp;
    next_count  = line_count;
    if (change) begin
      next_wp = wp + 1'b1;  // wraps onto the oldest line
      if (line_count != (LOG_AW+1)'(LOG_N))
        next_count = line_count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev       <= '0;
      primed     <= 1'b0;
      wp         <= '0;
      line_count <= '0;
      line_added <= 1'b0;
    end else begin
      prev       <= next_prev;
      primed     <= next_primed;
      wp         <= next_wp;
      line_count <= next_count;
      line_added <= change;
    end
  end

  // line store has no reset, it models persistent memory
  always_ff @(posedge core_clk) begin
    if (change)
      lines[wp] <= {stamp, watch};
  end

  // index 0 is always the oldest line held
  assign rd_phys  = line_count[LOG_AW] ? wp + rd_index : rd_index;
  assign rd_stamp = lines[rd_phys][TS_W+WATCH_W-1:WATCH_W];
  assign rd_state = lines[rd_phys][WATCH_W-1:0];

endmodule

`default_nettype wire

// File: bench/err_recorder_properties.sv
/* port checker for err_recorder: bus timing and interrupt behaviour.
   assumes the single core_clk domain and the bind at the foot */
`timescale 1ns/1ps
`default_nettype none

module err_recorder_properties
  import err_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rstn,
  input wire logic [7:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest,
  input wire logic [WATCH_W-1:0] watched_conditions,
  input wire logic               irq
);
  logic [1:0]         irq_mask;
  logic [WATCH_W-1:0] log_mask;
  logic               quiet_wr;

  // writes that may legally drop irq
  assign quiet_wr = avs_write && (avs_address == REG_IRQ_STAT ||
                    avs_address == REG_IRQ_MASK || avs_address == REG_CTRL);

  // mask mirrors, reset as in the design
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= 2'h0;
      log_mask <= '0;
    end else begin
      if (avs_write && avs_address == REG_IRQ_MASK) irq_mask <= avs_writedata[1:0];
      if (avs_write && avs_address == REG_LOG_MASK) log_mask <= avs_writedata[WATCH_W-1:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_WR_NO_WAIT: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
  AST_IDLE_NO_WAIT: assert property (!avs_read |-> !avs_waitrequest)
    else $error("wait without read");
  AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read missed its wait state");
  AST_RD_ONE: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait too long");
  AST_RD_HOLD: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved");
  AST_IRQ_MASKED: assert property (irq_mask == 2'h0 |-> !irq) else $error("masked irq raised");
  AST_IRQ_STICKY: assert property (irq && !quiet_wr |=> irq)
    else $error("irq dropped by itself");
  AST_LOG_IRQ: assert property (irq_mask[1] && ((watched_conditions ^
    $past(watched_conditions)) & log_mask) != '0 |-> ##[0:4] irq)
    else $error("change not flagged");

  CVR_IRQ: cover property ($rose(irq));
  CVR_READ: cover property (avs_read && avs_waitrequest ##1 !avs_waitrequest);
  CVR_CMD: cover property (avs_write && avs_address == REG_CMD);
endmodule

bind err_recorder err_recorder_properties i_props (.*);

`default_nettype wire

// File: bench/err_source_model.sv
/* protection-side model: one sample every 8 clocks, fields from a count.
   assumes the recorder takes samples on sample_valid */
`timescale 1ns/1ps
`default_nettype none

module err_source_model
  import err_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  output logic              sample_valid,
  output logic [CUR_W-1:0]  sample_current,
  output logic [VOLT_W-1:0] sample_voltage,
  output logic [FREQ_W-1:0] sample_frequency,
  output logic [ELEM_W-1:0] element_states,
  output logic [IN_W-1:0]   input_states,
  output logic [OUT_W-1:0]  output_states,
  output logic [TS_W-1:0]   date_time
);
  logic [2:0]  phase;
  logic [15:0] n;

  // free-running stream, so the ring holds the prefault samples before any trigger
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= '0;
      n <= '0;
      date_time <= '0;
    end else begin
      phase <= phase + 3'h1;
      date_time <= date_time + 32'h1;
      if (phase == 3'h7) n <= n + 16'h1;
    end
  end

  // fields rebuilt by the bench from the count alone
  assign sample_valid     = phase == 3'h0;
  assign sample_current   = n;
  assign sample_voltage   = ~n;
  assign sample_frequency = n;
  assign element_states   = n[7:0];
  assign input_states     = n[3:0];
  assign output_states    = n[3:0];
endmodule

`default_nettype wire

// File: bench/test_err_recorder.sv
/* self-checking bench for err_recorder with the source model.
   assumes the checker is bound to the design */
`timescale 1ns/1ps
`default_nettype none

module test_err_recorder
  import err_pkg::*;
;
  logic        core_clk, rstn, avs_read, avs_write, avs_waitrequest, irq;
  logic        sample_valid, report_trigger_equation;
  logic [7:0]  avs_address, element_states;
  logic [31:0] avs_writedata, avs_readdata, date_time;
  logic [15:0] sample_current, sample_voltage, sample_frequency, watched_conditions;
  logic [3:0]  input_states, output_states;
  int          n_errors = 0, n_checks = 0, cycles = 0;

  err_recorder i_dut (.*);
  err_source_model i_src (.*);

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string w);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, w, got, exp);
    end
  endtask

  // request held until waitrequest is seen low
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_read <= 1'b1;
    avs_address <= a;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e, input string w);
    logic [31:0] d;
    rd(a, d);
    chk(d & m, e, w);
  endtask
  task automatic rep(input logic [31:0] s, w, input logic [7:0] r, output logic [31:0] d);
    wr(REG_REP_SEL, s);
    wr(REG_REP_ADDR, w);
    rd(r, d);
  endtask
  task automatic wait_irq();
    int i;
    for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge core_clk);
    chk(irq, 32'h1, "irq");
    wr(REG_IRQ_STAT, 32'h1);
  endtask

  task automatic t_regs();
    rc(REG_CTRL, '1, 32'h0000_0400, "ctrl reset");
    rc(8'h3C, '1, 32'h0, "unmapped");
    rc(REG_STATUS, '1, 32'h0, "status reset");
    wr(REG_CTRL, 32'h0000_3C03);
    rc(REG_CTRL, '1, 32'h0000_0400, "bad ctrl kept");
    wr(REG_CTRL, 32'h0000_3B00);
    rc(REG_CTRL, '1, 32'h0000_3B00, "pre 59");
    wr(REG_IRQ_MASK, 32'h3);
  endtask

  // each length, capacity plus one so slot 0 is overwritten
  task automatic t_len();
    logic [15:0] n, w;
    logic [31:0] d;
    int          li, k, cap, v;
    for (li = 2; li >= 0; li--) begin
      cap = 2 << (2 - li);
      w = 16'd60 << li;
      wr(REG_CTRL, 32'h0000_0400 | li);
      rc(REG_STATUS, 32'h0000_FF00, 32'h0, "cleared");
      for (k = 0; k <= cap; k++) begin
        @(posedge core_clk iff sample_valid);
        n = sample_current;
        wr(REG_CMD, 32'h1);
        wait_irq();
        v = (k >= cap - 1) ? (1 << cap) - 1 : (2 << k) - 1;
        rc(REG_STATUS, 32'h0007_FF01, ((k + 1) % cap) << 16 | v << 8, "slots");
        rep(k % cap, 0, REG_REP_HI, d);
        chk(d[31:16], n - 16'd15, "first word");
        rep(k % cap, w - 16'd1, REG_REP_HI, d);
        chk(d[31:16], n - 16'd16 + w, "last word");
      end
    end
  endtask

  // prefault change, then a covered second equation edge
  task automatic t_eq();
    logic [15:0] m;
    logic [31:0] d, t;
    wr(REG_CTRL, 32'h0000_0A00);
    rc(REG_STATUS, 32'h0000_FF00, 32'h0000_FF00, "kept");
    @(posedge core_clk iff sample_valid);
    m = sample_current + 16'h1;
    t = date_time;
    report_trigger_equation <= 1'b1;
    repeat (40) @(posedge core_clk);
    report_trigger_equation <= 1'b0;
    repeat (40) @(posedge core_clk);
    report_trigger_equation <= 1'b1;
    wait_irq();
    repeat (300) @(posedge core_clk);
    rc(REG_STATUS, 32'h0007_0001, 32'h0002_0000, "one report");
    rc(REG_IRQ_STAT, 32'h1, 32'h0, "no second");
    rep(1, 40, REG_REP_HI, d);
    chk(d, {m, ~m}, "hi");
    rc(REG_REP_LO, '1, {m, m[7:0], m[3:0], m[3:0]}, "lo");
    rd(REG_REP_STAMP, d);
    chk(d - t < 32'd4, 32'h1, "stamp");
    report_trigger_equation <= 1'b0;
  endtask

  // unwatched change, then 513 watched changes
  task automatic t_log();
    int          k;
    logic [31:0] t;
    wr(REG_LOG_MASK, 32'h0000_000F);
    watched_conditions <= 16'h0100;
    repeat (8) @(posedge core_clk);
    rc(REG_LOG_COUNT, '1, 32'h0, "unwatched");
    for (k = 1; k <= 513; k++) begin
      @(posedge core_clk);
      watched_conditions <= 16'h0100 | k[3:0];
      t = date_time;
    end
    repeat (8) @(posedge core_clk);
    rc(REG_LOG_COUNT, '1, 32'd512, "count");
    wr(REG_LOG_INDEX, 32'h0);
    rc(REG_LOG_STATE, 32'hF, 32'h2, "oldest");
    wr(REG_LOG_INDEX, 32'd511);
    rc(REG_LOG_STATE, 32'hF, 32'h1, "newest");
    rc(REG_LOG_STAMP, '1, t + 32'h1, "log stamp");
    rc(REG_IRQ_STAT, 32'h3, 32'h2, "log flag");
    wr(REG_IRQ_MASK, 32'h1);
    @(posedge core_clk);
    chk(irq, 32'h0, "masked");
    wr(REG_IRQ_STAT, 32'h2);
    rc(REG_IRQ_STAT, 32'h3, 32'h0, "w1c");
  endtask

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard, over twice the run's length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      test_done();
    end
  end

  // reset, then let the ring gather the prefault samples before the first capture
  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    report_trigger_equation = 1'b0;
    watched_conditions = 16'h0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (300) @(posedge core_clk);
    t_regs();
    t_len();
    t_eq();
    t_log();
    test_done();
  end
endmodule

`default_nettype wire
